// ### common/dmac_params.svh
// Purpose: constants of the DMA address and configuration block
// Assumes: register index times four gives the byte address
// Notes: Behaviour list below
// Behaviour
// - Increment address by width in bytes
// - Constant bit forces zero increment
// - Length width parameter, 1 to 32 bits
// - Length spans slaves, wider override allowed
// - Optional bursts capped by maximum burst size
// - Data FIFO depth is a parameter
// - FIFO built from flops or memory
// - Each transfer width above byte enabled at build; byte always available
// - Transfer unit sets access width and step
// - Receive streaming reads one fixed address
// - Transmit streaming writes one fixed address
// - FIFO depth two; writes follow FIFO data
// - Length decrements per write, stops at zero
// - Done on end-of-packet or length complete
`ifndef DMAC_PARAMS_SVH
`define DMAC_PARAMS_SVH
// Register indices; byte address is index times four
`define DMAC_IDX_STATUS 4'h0
`define DMAC_IDX_RDADDR 4'h1
`define DMAC_IDX_WRADDR 4'h2
`define DMAC_IDX_LENGTH 4'h3
`define DMAC_IDX_CONTROL 4'h6
`define DMAC_IDX_MASK 4'h8
// Status bits
`define DMAC_ST_DONE 0
`define DMAC_ST_BUSY 1
`define DMAC_ST_REOP 2
`define DMAC_ST_WEOP 3
`define DMAC_ST_LEN 4
// Control bits
`define DMAC_CT_BYTE 0
`define DMAC_CT_HALF 1
`define DMAC_CT_WORD 2
`define DMAC_CT_GO 3
`define DMAC_CT_IEN 4
`define DMAC_CT_REEN 5
`define DMAC_CT_WEEN 6
`define DMAC_CT_LEEN 7
`define DMAC_CT_READ_CONSTANT_ADDRESS 8
`define DMAC_CT_WRITE_CONSTANT_ADDRESS 9
`define DMAC_CT_DWORD 10
`define DMAC_CT_QWORD 11
`define DMAC_CT_SWRST 12
`define DMAC_CTRL_W 13
`define DMAC_CTRL_RST 13'h0000
`define DMAC_MASK_RST 5'h00
// Address steps in bytes
`define DMAC_STEP_BYTE 5'h01
`define DMAC_STEP_HALF 5'h02
`define DMAC_STEP_WORD 5'h04
`define DMAC_STEP_DWORD 5'h08
`define DMAC_STEP_QWORD 5'h10
// Build defaults
`define DMAC_FIFO_DEPTH 2
`define DMAC_LEN_MIN_W 13
`define DMAC_ALLOWED 5'h1F
`define DMAC_MAX_BURST 16
`endif

// ### common/dmac_pkg.sv
// Purpose: types of the DMA address and configuration block
// Assumes: constants live in dmac_params.svh
// Notes: none
package dmac_pkg;
	typedef enum logic [1:0] {DMAC_IDLE, DMAC_RUN} dmac_state_t;
	typedef logic [4:0] dmac_step_t;
	typedef logic [2:0] dmac_size_t;
endpackage : dmac_pkg

// ### sim/dmac_mem_model.sv
// Purpose: read and write slave model facing the DMA masters
// Assumes: one beat per ack; eop marks every ack of that side
// Notes: wait states set by dly
`timescale 1ns/1ps
module dmac_mem_model (
	input wire logic clk,
	input wire logic [1:0] dly,
	input wire logic [1:0] eop,
	input wire logic rd_req,
	input wire logic [31:0] rd_addr,
	output logic rd_ack,
	output logic [31:0] rd_data,
	output logic rd_eop,
	input wire logic wr_req,
	input wire logic [31:0] wr_addr,
	input wire logic [2:0] wr_size,
	input wire logic [31:0] wr_data,
	output logic wr_ack,
	output logic wr_eop
);
	logic [1:0] rc;
	logic [1:0] wc;
	logic [2:0] lsz;
	logic [31:0] wa[$];
	logic [31:0] wd[$];
	// Data valid only with ack; inverted otherwise so stale reads show
	assign rd_data = (rd_addr ^ 32'hA5A50000) ^ {32{!rd_ack}};
	assign rd_eop = rd_ack & eop[0];
	assign wr_eop = wr_ack & eop[1];
	initial begin
		rd_ack = 1'b0;
		wr_ack = 1'b0;
		rc = 2'h0;
		wc = 2'h0;
	end
	always @(posedge clk) begin
		rd_ack <= 1'b0;
		wr_ack <= 1'b0;
		if (rd_req && !rd_ack) begin
			rc <= rc + 2'h1;
			if (rc == dly) begin
				rd_ack <= 1'b1;
				rc <= 2'h0;
			end
		end
		if (wr_req && !wr_ack) begin
			wc <= wc + 2'h1;
			if (wc == dly) begin
				wr_ack <= 1'b1;
				wc <= 2'h0;
				wa.push_back(wr_addr);
				wd.push_back(wr_data);
				lsz <= wr_size;
			end
		end
	end
endmodule : dmac_mem_model

// ### sim/dmac_top_sva.sv
// Purpose: port checks of the DMA block
// Assumes: control written only while idle
// Notes: address steps tracked from control writes
`timescale 1ns/1ps
module dmac_top_sva #(
	parameter int ADDR_W = 32,
	parameter int DATA_W = 32,
	parameter int FIFO_DEPTH = 2
) (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic RD_REQ,
	input wire logic [ADDR_W-1:0] RD_ADDR,
	input wire logic [2:0] RD_SIZE,
	input wire logic RD_ACK,
	input wire logic WR_REQ,
	input wire logic [ADDR_W-1:0] WR_ADDR,
	input wire logic [2:0] WR_SIZE,
	input wire logic [DATA_W-1:0] WR_DATA,
	input wire logic WR_ACK
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	logic ctl_ph;
	logic rd_fix;
	logic wr_fix;
	logic [3:0] lvl;
	logic [ADDR_W-1:0] rnext;
	logic [ADDR_W-1:0] wnext;
	wire logic rd_ph = HSEL && HREADY && HTRANS[1] && !HWRITE;
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ctl_ph <= 1'b0;
			rd_fix <= 1'b0;
			wr_fix <= 1'b0;
			lvl <= 4'h0;
		end else begin
			ctl_ph <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == 32'h18;
			if (ctl_ph) begin
				rd_fix <= HWDATA[8];
				wr_fix <= HWDATA[9];
			end
			lvl <= lvl + {3'h0, RD_REQ && RD_ACK} - {3'h0, WR_REQ && WR_ACK};
		end
	end
	// Expected next address, kept even when no ack lands
	always_ff @(posedge CLK_SYS) begin
		rnext <= RD_ADDR + (rd_fix ? '0 : ADDR_W'(5'h01) << RD_SIZE);
		wnext <= WR_ADDR + (wr_fix ? '0 : ADDR_W'(5'h01) << WR_SIZE);
	end
	AST_RD_HOLD: assert property (
		RD_REQ && !RD_ACK |=> RD_REQ && $stable(RD_ADDR))
		else $error("read request changed before ack");
	AST_RD_DROP: assert property (
		RD_REQ && RD_ACK |=> !RD_REQ)
		else $error("read request not dropped after ack");
	AST_RD_STEP: assert property (
		RD_REQ && RD_ACK |=> RD_ADDR == rnext)
		else $error("read address step wrong");
	AST_WR_HOLD: assert property (
		WR_REQ && !WR_ACK |=>
		WR_REQ && $stable(WR_ADDR) && $stable(WR_DATA))
		else $error("write request changed before ack");
	AST_WR_DROP: assert property (
		WR_REQ && WR_ACK |=> !WR_REQ)
		else $error("write request not dropped after ack");
	AST_WR_STEP: assert property (
		WR_REQ && WR_ACK |=> WR_ADDR == wnext)
		else $error("write address step wrong");
	AST_FIFO_DATA: assert property (WR_REQ |-> lvl != 4'h0)
		else $error("write requested with empty FIFO");
	// FIFO plus the word held on the write side
	AST_FIFO_CAP: assert property (
		lvl <= 4'(FIFO_DEPTH + 1))
		else $error("more words read than FIFO holds");
	AST_SIZE: assert property (
		RD_REQ |-> RD_SIZE == WR_SIZE && RD_SIZE <= 3'h4)
		else $error("transfer size mismatch");
	AST_READ_WAIT: assert property (
		rd_ph |=> !HREADYOUT ##1 HREADYOUT)
		else $error("register read wait state wrong");
	// Register bus always answers OKAY
	AST_OKAY: assert property (HRESP == 1'b0)
		else $error("register bus response not OKAY");
	C_RD_FIX: cover property (RD_REQ && RD_ACK && rd_fix);
	C_WR_FIX: cover property (WR_REQ && WR_ACK && wr_fix);
	C_RD_PH: cover property (rd_ph);
endmodule : dmac_top_sva
bind dmac_top dmac_top_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
	.FIFO_DEPTH(FIFO_DEPTH)) dmac_top_sva_inst (.*);

// ### sim/tb_top.sv
// Purpose: register-level test of the DMA block
// Assumes: memory model answers with 0 to 2 wait states
// Notes: one word per beat; end-of-packet runs near the end
`timescale 1ns/1ps
module tb_top;
	logic CLK_SYS, NRST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, IRQ;
	logic RD_REQ, RD_ACK, RD_EOP, WR_REQ, WR_ACK, WR_EOP;
	logic [31:0] HADDR, HWDATA, HRDATA, RD_ADDR, RD_DATA, WR_ADDR, WR_DATA;
	logic [31:0] r, st, ex, step;
	logic [1:0] HTRANS, dly, eop;
	logic [2:0] HSIZE, RD_SIZE, WR_SIZE;
	logic [7:0] RD_BURSTCOUNT, WR_BURSTCOUNT;
	logic [31:0] wb[5] = '{32'h1, 32'h2, 32'h4, 32'h400, 32'h800};
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int k;
	assign HREADY = HREADYOUT;
	dmac_top dmac_top_inst (.*);
	dmac_mem_model mem_inst (.clk(CLK_SYS), .dly(dly), .eop(eop),
		.rd_req(RD_REQ), .rd_addr(RD_ADDR), .rd_ack(RD_ACK),
		.rd_data(RD_DATA),
		.rd_eop(RD_EOP), .wr_req(WR_REQ), .wr_addr(WR_ADDR),
		.wr_size(WR_SIZE), .wr_data(WR_DATA), .wr_ack(WR_ACK),
		.wr_eop(WR_EOP));
	initial begin
		CLK_SYS = 1'b0;
		forever #2 CLK_SYS = ~CLK_SYS;
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("failures %0d n_compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wt;
		@(posedge CLK_SYS);
		while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
	endtask : wt
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		wt();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wt();
		q = HRDATA;
	endtask : bus
	task automatic wr(input logic [31:0] a, d);
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rdc(input string n, input logic [31:0] a, e);
		bus(1'b0, a, 32'h0, r);
		chk(n, r, e);
	endtask : rdc
	initial begin
		NRST = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		dly = 2'h0;
		eop = 2'h0;
		repeat (20) @(posedge CLK_SYS);
		NRST <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		rdc("status", 32'h00, 32'h0);
		rdc("control", 32'h18, 32'h0);
		rdc("mask", 32'h20, 32'h0);
		wr(32'h10, 32'hFFFFFFFF);
		rdc("unmapped", 32'h10, 32'h0);
		// Every width, with all four fixed-address combinations
		for (k = 0; k < 5; k++) begin
			step = 32'h1 << k;
			dly <= 2'(k % 3);
			wr(32'h04, 32'h100);
			wr(32'h08, 32'h200);
			wr(32'h0C, 3 * step);
			wr(32'h18, wb[k] | {22'h0, k[1], k[0], 8'h88});
			st = 32'h0;
			for (int i = 0; i < 100 && st[0] !== 1'b1; i++)
				bus(1'b0, 32'h00, 32'h0, st);
			chk("status", st, 32'h11);
			rdc("length", 32'h0C, 32'h0);
			chk("writes", 32'(mem_inst.wa.size()), 32'h3);
			for (int i = 0; i < 3; i++) begin
				ex = 32'h200 + (k[1] ? 32'h0 : i * step);
				chk("waddr", mem_inst.wa[i], ex);
				ex = (32'h100 + (k[0] ? 32'h0 : i * step)) ^ 32'hA5A50000;
				chk("wdata", mem_inst.wd[i], ex);
			end
			chk("size", {29'h0, mem_inst.lsz}, k);
			chk("rburst", {24'h0, RD_BURSTCOUNT}, 32'h1);
			chk("wburst", {24'h0, WR_BURSTCOUNT}, 32'h1);
			mem_inst.wa.delete();
			mem_inst.wd.delete();
			wr(32'h00, 32'h1F);
			rdc("status", 32'h00, 32'h0);
		end
		// Read side, then write side end-of-packet on the first word
		for (k = 0; k < 2; k++) begin
			eop <= 2'(k + 1);
			wr(32'h0C, k[0] ? 32'h4 : 32'hC);
			wr(32'h18, k[0] ? 32'h4C : 32'h2C);
			st = 32'h0;
			for (int i = 0; i < 100 && st[0] !== 1'b1; i++)
				bus(1'b0, 32'h00, 32'h0, st);
			chk("eopst", st, k[0] ? 32'h19 : 32'h05);
			rdc("eoplen", 32'h0C, k[0] ? 32'h0 : 32'h8);
			chk("eopwr", 32'(mem_inst.wa.size()), 32'h1);
			mem_inst.wa.delete();
			mem_inst.wd.delete();
			wr(32'h00, 32'h1F);
		end
		eop <= 2'h0;
		// Zero length ends at once; interrupt held off by the mask, then unmasked and cleared
		wr(32'h0C, 32'h0);
		wr(32'h18, 32'h0C);
		repeat (4) @(posedge CLK_SYS);
		bus(1'b0, 32'h00, 32'h0, st);
		chk("done", st & 32'h1, 32'h1);
		chk("irq", {31'h0, IRQ}, 32'h0);
		wr(32'h20, 32'h1);
		repeat (2) @(posedge CLK_SYS);
		chk("irq", {31'h0, IRQ}, 32'h1);
		wr(32'h00, 32'h1F);
		repeat (2) @(posedge CLK_SYS);
		chk("irq", {31'h0, IRQ}, 32'h0);
		end_of_test();
	end
endmodule : tb_top

// ### verilog/dmac_fifo.sv
// Purpose: data FIFO between read and write sides
// Assumes: one clock, synchronous flush
// Notes: both storage styles give the same data whenever out_valid is set
`timescale 1ns/1ps
module dmac_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2,
	parameter bit USE_MEM = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = store[rp];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end else if (flush) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end else begin
			if (push)
				wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
			if (pop)
				rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	generate
		if (USE_MEM) begin : g_mem
			// Memory style: no reset on storage, like block RAM
			always_ff @(posedge clk) begin
				if (push)
					store[wp] <= in_data;
			end
		end else begin : g_reg
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					for (int i = 0; i < DEPTH; i++)
						store[i] <= '0;
				end else if (push) begin
					store[wp] <= in_data;
				end
			end
		end
	endgenerate
endmodule : dmac_fifo

// ### verilog/dmac_top.sv
// Purpose: DMA engine address generation, config and register slave
// Assumes: read and write masters answer with a same-clock ack
// Notes: registers reached over AHB-Lite, reads take one wait state
`timescale 1ns/1ps
`include "dmac_params.svh"
module dmac_top #(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 32,
	// minimum length width, 1 to 32
	parameter int LEN_MIN_W = `DMAC_LEN_MIN_W,
	parameter int FIFO_DEPTH = `DMAC_FIFO_DEPTH,
	parameter bit FIFO_USE_MEM = 1'b0,
	// enabled widths, bit 1 halfword up to bit 4 quadword; bit 0 unused, byte always on
	parameter logic [4:0] ALLOWED = `DMAC_ALLOWED,
	parameter bit BURST_EN = 1'b0,
	parameter int MAX_BURST = `DMAC_MAX_BURST,
	parameter int BCNT_W = 8
) (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ,
	output logic RD_REQ,
	output logic [ADDR_W-1:0] RD_ADDR,
	output logic [2:0] RD_SIZE,
	output logic [BCNT_W-1:0] RD_BURSTCOUNT,
	input wire logic RD_ACK,
	input wire logic [DATA_W-1:0] RD_DATA,
	input wire logic RD_EOP,
	output logic WR_REQ,
	output logic [ADDR_W-1:0] WR_ADDR,
	output logic [2:0] WR_SIZE,
	output logic [BCNT_W-1:0] WR_BURSTCOUNT,
	output logic [DATA_W-1:0] WR_DATA,
	input wire logic WR_ACK,
	input wire logic WR_EOP
);
	// length spans the address range unless widened
	localparam int LEN_W = (LEN_MIN_W > ADDR_W) ? LEN_MIN_W : ADDR_W;

	logic rst_meta, rst_n, a_valid, a_write, a_map, rd_wait;
	logic [3:0] a_idx;
	logic [`DMAC_CTRL_W-1:0] ctrl;
	logic [ADDR_W-1:0] rd_start, wr_start;
	logic [4:0] mask;
	logic [3:0] sticky, sticky_set;
	dmac_pkg::dmac_state_t state;
	logic busy, rd_stop, go, wr_len, soft_rst;
	logic [LEN_W-1:0] len_cnt, rd_left;
	logic [BCNT_W-1:0] burst;
	logic [2:0] size;
	dmac_pkg::dmac_step_t step, rd_inc, wr_inc;
	logic push, pop, f_ready, f_valid;
	logic [DATA_W-1:0] f_data;
	logic wr_done, len_zero, weop_end, reop_end, finish;

	// pick the widest selected width that is enabled
	// selection sets step for both masters
	function automatic dmac_pkg::dmac_step_t step_of(
		input logic [`DMAC_CTRL_W-1:0] c);
		if (c[`DMAC_CT_QWORD] && ALLOWED[4])
			return `DMAC_STEP_QWORD;
		else if (c[`DMAC_CT_DWORD] && ALLOWED[3])
			return `DMAC_STEP_DWORD;
		else if (c[`DMAC_CT_WORD] && ALLOWED[2])
			return `DMAC_STEP_WORD;
		else if (c[`DMAC_CT_HALF] && ALLOWED[1])
			return `DMAC_STEP_HALF;
		else
			return `DMAC_STEP_BYTE;
	endfunction : step_of

	function automatic dmac_pkg::dmac_size_t size_of(
		input dmac_pkg::dmac_step_t s);
		case (s)
			`DMAC_STEP_QWORD: return 3'h4;
			`DMAC_STEP_DWORD: return 3'h3;
			`DMAC_STEP_WORD: return 3'h2;
			`DMAC_STEP_HALF: return 3'h1;
			default: return 3'h0;
		endcase
	endfunction : size_of

	function automatic logic [LEN_W-1:0] dec_len(
		input logic [LEN_W-1:0] v, input dmac_pkg::dmac_step_t s);
		return (v > LEN_W'(s)) ? v - LEN_W'(s) : '0;
	endfunction : dec_len

	// Two-flop reset release; asynchronous assertion
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Bus address phase capture
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_idx <= 4'h0;
			a_map <= 1'b0;
		end else if (HREADY) begin
			a_valid <= HSEL & HTRANS[1];
			a_write <= HWRITE;
			a_idx <= HADDR[5:2];
			a_map <= (HADDR[31:6] == 26'h0000000);
		end
	end

	// Reads get one wait state so a write just before is seen
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			rd_wait <= 1'b0;
			HRDATA <= 32'h00000000;
		end else begin
			HRESP <= 1'b0;
			rd_wait <= 1'b0;
			HREADYOUT <= 1'b1;
			if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
				HREADYOUT <= 1'b0;
				rd_wait <= 1'b1;
			end
			if (rd_wait) begin
				HRDATA <= 32'h00000000;
				if (a_map) begin
					case (a_idx)
						`DMAC_IDX_STATUS:
							HRDATA <= {27'h0000000, sticky[3],
								sticky[2], sticky[1], busy, sticky[0]};
						`DMAC_IDX_RDADDR:
							HRDATA <= 32'(rd_start);
						`DMAC_IDX_WRADDR:
							HRDATA <= 32'(wr_start);
						`DMAC_IDX_LENGTH:
							HRDATA <= 32'(len_cnt);
						`DMAC_IDX_CONTROL:
							HRDATA <= 32'(ctrl);
						`DMAC_IDX_MASK:
							HRDATA <= 32'(mask);
						default:
							HRDATA <= 32'h00000000;
					endcase
				end
			end
		end
	end

	function automatic logic wr_hit(input logic [3:0] idx);
		return a_valid & a_write & a_map & (a_idx == idx);
	endfunction : wr_hit

	assign go = wr_hit(`DMAC_IDX_CONTROL) & HWDATA[`DMAC_CT_GO] &
		!busy;
	assign wr_len = wr_hit(`DMAC_IDX_LENGTH) & !busy;
	assign soft_rst = wr_hit(`DMAC_IDX_CONTROL) & HWDATA[`DMAC_CT_SWRST];

	// Configuration registers
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `DMAC_CTRL_RST;
			rd_start <= '0;
			wr_start <= '0;
			mask <= `DMAC_MASK_RST;
		end else begin
			if (wr_hit(`DMAC_IDX_CONTROL))
				ctrl <= HWDATA[`DMAC_CTRL_W-1:0] &
					~(`DMAC_CTRL_W'(1) << `DMAC_CT_SWRST);
			// host aligns addresses; low bits kept as written
			if (wr_hit(`DMAC_IDX_RDADDR) && !busy)
				rd_start <= HWDATA[ADDR_W-1:0];
			if (wr_hit(`DMAC_IDX_WRADDR) && !busy)
				wr_start <= HWDATA[ADDR_W-1:0];
			if (wr_hit(`DMAC_IDX_MASK))
				mask <= HWDATA[4:0];
		end
	end

	assign step = step_of(ctrl);
	// receive streaming holds the read address
	assign rd_inc = ctrl[`DMAC_CT_READ_CONSTANT_ADDRESS] ? 5'h00 : step;
	// transmit streaming holds the write address
	assign wr_inc = ctrl[`DMAC_CT_WRITE_CONSTANT_ADDRESS] ? 5'h00 : step;

	assign push = RD_REQ & RD_ACK;
	// write side starts from FIFO data only
	assign pop = (state == dmac_pkg::DMAC_RUN) & f_valid & !WR_REQ;
	assign wr_done = WR_REQ & WR_ACK;
	assign len_zero = wr_done & (dec_len(len_cnt, step) == '0);
	assign weop_end = wr_done & WR_EOP & ctrl[`DMAC_CT_WEEN];
	assign reop_end = (state == dmac_pkg::DMAC_RUN) & rd_stop &
		!RD_REQ & !WR_REQ & !f_valid;
	assign finish = (state == dmac_pkg::DMAC_RUN) &
		(len_zero | weop_end | reop_end | (len_cnt == '0));

	dmac_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.USE_MEM(FIFO_USE_MEM)
	) u_fifo (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.flush(soft_rst | go),
		.in_valid(push),
		.in_ready(f_ready),
		.in_data(RD_DATA),
		.out_valid(f_valid),
		.out_ready(pop),
		.out_data(f_data)
	);

	// Transaction state and busy
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state <= dmac_pkg::DMAC_IDLE;
			busy <= 1'b0;
			size <= 3'h0;
			burst <= '0;
		end else if (soft_rst) begin
			state <= dmac_pkg::DMAC_IDLE;
			busy <= 1'b0;
		end else begin
			case (state)
				dmac_pkg::DMAC_IDLE: begin
					if (go) begin
						state <= dmac_pkg::DMAC_RUN;
						busy <= 1'b1;
						size <= size_of(step_of(
							HWDATA[`DMAC_CTRL_W-1:0]));
						if (!BURST_EN)
							burst <= BCNT_W'(1);
						else if ((len_cnt >> size_of(step_of(
							HWDATA[`DMAC_CTRL_W-1:0]))) >
							LEN_W'(MAX_BURST))
							burst <= BCNT_W'(MAX_BURST);
						else
							burst <= BCNT_W'(len_cnt >> size_of(
								step_of(HWDATA[`DMAC_CTRL_W-1:0])));
					end
				end
				dmac_pkg::DMAC_RUN: begin
					if (finish) begin
						state <= dmac_pkg::DMAC_IDLE;
						busy <= 1'b0;
					end
				end
				default: begin
					state <= dmac_pkg::DMAC_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// Read master
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			RD_REQ <= 1'b0;
			RD_ADDR <= '0;
			rd_left <= '0;
			rd_stop <= 1'b0;
		end else if (soft_rst || finish) begin
			RD_REQ <= 1'b0;
			rd_stop <= 1'b0;
			// an ack landing at the end still steps
			if (push)
				RD_ADDR <= RD_ADDR + ADDR_W'(rd_inc);
		end else if (go) begin
			RD_ADDR <= rd_start;
			rd_left <= len_cnt;
			rd_stop <= 1'b0;
		end else if (state == dmac_pkg::DMAC_RUN) begin
			// step only once the read is acknowledged
			if (push) begin
				RD_REQ <= 1'b0;
				RD_ADDR <= RD_ADDR + ADDR_W'(rd_inc);
				rd_left <= dec_len(rd_left, step);
				if (RD_EOP && ctrl[`DMAC_CT_REEN])
					rd_stop <= 1'b1;
			end else if (!RD_REQ && rd_left != '0 && !rd_stop &&
				f_ready) begin
				// One access in flight keeps FIFO room guaranteed
				RD_REQ <= 1'b1;
			end
		end
	end

	// Write master and length count
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			WR_REQ <= 1'b0;
			WR_ADDR <= '0;
			WR_DATA <= '0;
			len_cnt <= '0;
		end else if (soft_rst) begin
			WR_REQ <= 1'b0;
		end else if (wr_len) begin
			len_cnt <= HWDATA[LEN_W-1:0];
		end else if (go) begin
			WR_ADDR <= wr_start;
		end else begin
			if (pop) begin
				WR_REQ <= 1'b1;
				WR_DATA <= f_data;
			end
			// step only once the write is acknowledged
			if (wr_done) begin
				WR_REQ <= 1'b0;
				WR_ADDR <= WR_ADDR + ADDR_W'(wr_inc);
				len_cnt <= dec_len(len_cnt, step);
			end
		end
	end

	assign sticky_set = {len_zero, weop_end, reop_end, finish};

	// Sticky status, write one clears, set wins
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			sticky <= 4'h0;
		end else if (wr_hit(`DMAC_IDX_STATUS)) begin
			sticky <= sticky_set | (sticky & ~{HWDATA[`DMAC_ST_LEN],
				HWDATA[`DMAC_ST_WEOP], HWDATA[`DMAC_ST_REOP],
				HWDATA[`DMAC_ST_DONE]});
		end else begin
			sticky <= sticky | sticky_set;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n)
			IRQ <= 1'b0;
		else
			IRQ <= |({sticky[3], sticky[2], sticky[1], 1'b0,
				sticky[0]} & mask);
	end

	assign RD_SIZE = size;
	assign WR_SIZE = size;
	assign RD_BURSTCOUNT = burst;
	assign WR_BURSTCOUNT = burst;
endmodule : dmac_top
